// ===== amrs_cfg.svh
// constants for the async memory read strobe sequencer
`ifndef AMRS_CFG_SVH
`define AMRS_CFG_SVH
`define AMRS_CLK_PERIOD_NS 10
`define AMRS_WAIT_UNIT 16
`define AMRS_WAIT_DEADLINE_CYC 4
`define AMRS_CS_WIDTH 4
`define AMRS_BA_WIDTH 2
`define AMRS_ADDR_WIDTH 21
`define AMRS_DATA_WIDTH 16
`define AMRS_CNT_WIDTH 8
`define AMRS_UNIT_WIDTH 4
`endif

// ===== amrs_mem_model.sv
// behavioural async memory with wait pin for the sequencer bench
`timescale 1ns/1ns
`include "amrs_cfg.svh"
module amrs_mem_model (
  // clock
  input wire logic ref_clk,
  // memory pins
  input wire logic [`AMRS_CS_WIDTH-1:0] chip_select_n,
  input wire logic output_enable_n,
  input wire logic [`AMRS_ADDR_WIDTH-1:0] word_address,
  output logic memory_wait_input,
  output logic [`AMRS_DATA_WIDTH-1:0] memory_data_bus,
  // cycles of wait from strobe start, 0 for none
  input wire logic [7:0] wait_len
);
  logic [7:0] wcnt = 8'h00;
  logic [15:0] last = 16'h0000;
  // released bus shows the inverse of the last word, never a stale match
  assign memory_data_bus = (!output_enable_n && chip_select_n != 4'hf) ?
    (word_address[15:0] ^ 16'ha5c3) : ~last;
  // wait rises with the strobe, well before its end, and holds for wait_len cycles
  assign memory_wait_input = !output_enable_n && (wcnt < wait_len);
  always @(posedge ref_clk) begin
    if (!output_enable_n) begin
      last <= memory_data_bus;
    end
    if (output_enable_n) begin
      wcnt <= 8'h00;
    end else if (wcnt != 8'hff) begin
      wcnt <= wcnt + 8'h01;
    end
  end
endmodule // amrs_mem_model

// ===== amrs_pkg.sv
// types for the async memory read strobe sequencer
package amrs_pkg;
  typedef enum logic [2:0] {
    AMRS_IDLE = 3'b000,
    AMRS_TURN = 3'b001,
    AMRS_SETUP = 3'b010,
    AMRS_STROBE = 3'b011,
    AMRS_EXTEND = 3'b100,
    AMRS_HOLD = 3'b101
  } amrs_state_e;
endpackage

// ===== amrs_seq.sv
// read timing sequencer for asynchronous memory
`timescale 1ns/1ns
`include "amrs_cfg.svh"
// Function
// - all phase durations are counted in whole system clock cycles
// - without extended wait a read lasts setup plus strobe plus hold cycles
// - with extended wait, read grows sixteen cycles per wait unit
// - select-strobe off: chip select leads output enable by setup count
// - select-strobe off: chip select trails output enable by hold count
// - select-strobe on: chip select falls and rises with output enable
// - addresses valid for the setup count before output enable falls
// - addresses held for the hold count after output enable rises
// - without extended wait output enable is low for the strobe count
// - with extended wait output enable low stretches by sixteen per unit
// - wait deadline is measured to the unextended hold start
// - all counts but the sixteen-cycle wait unit and the wait deadline come from software-programmable configuration inputs
// - stop waiting after the programmed maximum wait units, flag timeout
module amrs_seq
  import amrs_pkg::*;
#(
  parameter int CNT_W = `AMRS_CNT_WIDTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // configuration
  input wire logic extended_wait_enable,
  input wire logic select_strobe_mode,
  input wire logic [CNT_W-1:0] turnaround_cycles,
  input wire logic [CNT_W-1:0] read_setup_cycles,
  input wire logic [CNT_W-1:0] read_strobe_cycles,
  input wire logic [CNT_W-1:0] read_hold_cycles,
  input wire logic [CNT_W-1:0] max_wait_timeout,
  // request
  input wire logic req_valid,
  input wire logic [`AMRS_BA_WIDTH-1:0] req_bank,
  input wire logic [`AMRS_ADDR_WIDTH-1:0] req_addr,
  input wire logic [`AMRS_CS_WIDTH-1:0] req_cs_sel,
  // status
  output logic req_ready,
  output logic read_done,
  output logic wait_timeout,
  output logic [`AMRS_DATA_WIDTH-1:0] read_data,
  // memory pins
  input wire logic memory_wait_input,
  input wire logic [`AMRS_DATA_WIDTH-1:0] memory_data_bus,
  output logic [`AMRS_CS_WIDTH-1:0] chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  output logic [`AMRS_BA_WIDTH-1:0] bank_address,
  output logic [`AMRS_ADDR_WIDTH-1:0] word_address
);
  if (CNT_W < 2 || CNT_W > 16) begin : g_cnt_w_check
    $error("amrs_seq: CNT_W out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    amrs_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [`AMRS_UNIT_WIDTH-1:0] unit;
    logic [CNT_W-1:0] extended_wait_count;
    logic ew;
    logic ss;
    logic [`AMRS_CS_WIDTH-1:0] sel;
    logic [`AMRS_CS_WIDTH-1:0] cs_n;
    logic oe_n;
    logic [`AMRS_BA_WIDTH-1:0] ba;
    logic [`AMRS_ADDR_WIDTH-1:0] addr;
    logic ready;
    logic done;
    logic grab;
    logic tmo;
    logic [`AMRS_DATA_WIDTH-1:0] data;
  } amrs_regs_s;

  amrs_regs_s s_q, s_d;
  logic wait_s;
  logic [`AMRS_DATA_WIDTH-1:0] data_s1_q;

  // wait pin passes two flops; data pin sampled in a stage too
  amrs_sync u_wait_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(memory_wait_input),
    .sync_out(wait_s)
  );

  // data is stable around the strobe end; one stage keeps it off logic
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_s1_q <= '0;
    end else begin
      data_s1_q <= memory_data_bus;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);
  localparam logic [`AMRS_UNIT_WIDTH-1:0] UNIT_LAST =
    `AMRS_UNIT_WIDTH'(`AMRS_WAIT_UNIT - 1);

  function automatic logic [CNT_W-1:0] lim(input logic [CNT_W-1:0] v);
    lim = (v == '0) ? ONE : v;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.grab = 1'b0;
    // one edge after strobe end the stage holds the last driven word,
    // so a one-cycle strobe still returns fresh data
    if (s_q.grab) begin
      s_d.data = data_s1_q;
    end
    unique case (s_q.st)
      AMRS_IDLE: begin
        s_d.ready = 1'b1;
        if (req_valid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.ew = extended_wait_enable;
          s_d.ss = select_strobe_mode;
          s_d.sel = req_cs_sel;
          s_d.ba = req_bank;
          s_d.addr = req_addr;
          s_d.cnt = lim(read_setup_cycles);
          s_d.extended_wait_count = '0;
          s_d.tmo = 1'b0;
          s_d.st = AMRS_SETUP;
          if (!select_strobe_mode) begin
            s_d.cs_n = ~req_cs_sel;
          end
        end
      end
      AMRS_SETUP: begin
        s_d.cnt = s_q.cnt - ONE;
        if (s_q.cnt == ONE) begin
          s_d.oe_n = 1'b0;
          if (s_q.ss) begin
            s_d.cs_n = ~s_q.sel;
          end
          s_d.cnt = lim(read_strobe_cycles);
          s_d.st = AMRS_STROBE;
        end
      end
      AMRS_STROBE: begin
        s_d.cnt = s_q.cnt - ONE;
        // wait seen by deadline before unextended hold start
        // after a timeout the strobe runs out, no new wait is honoured
        if (s_q.ew && !s_q.tmo && wait_s
            && s_q.cnt <= CNT_W'(`AMRS_WAIT_DEADLINE_CYC)
            && s_q.cnt != ONE) begin
          s_d.unit = '0;
          s_d.st = AMRS_EXTEND;
        end else if (s_q.cnt == ONE) begin
          s_d.oe_n = 1'b1;
          s_d.grab = 1'b1;
          if (s_q.ss) begin
            s_d.cs_n = '1;
          end
          s_d.cnt = lim(read_hold_cycles);
          s_d.st = AMRS_HOLD;
        end
      end
      AMRS_EXTEND: begin
        // extension in units of sixteen, remaining strobe count frozen
        s_d.unit = s_q.unit + `AMRS_UNIT_WIDTH'(1);
        if (s_q.unit == UNIT_LAST) begin
          s_d.extended_wait_count = s_q.extended_wait_count + ONE;
          if (s_q.extended_wait_count + ONE >= max_wait_timeout) begin
            s_d.tmo = 1'b1;
            s_d.st = AMRS_STROBE;
          end else if (!wait_s) begin
            s_d.st = AMRS_STROBE;
          end
        end
      end
      AMRS_HOLD: begin
        s_d.cnt = s_q.cnt - ONE;
        if (s_q.cnt == ONE) begin
          s_d.cs_n = '1;
          s_d.done = 1'b1;
          s_d.cnt = turnaround_cycles;
          s_d.st = (turnaround_cycles == '0) ? AMRS_IDLE : AMRS_TURN;
        end
      end
      AMRS_TURN: begin
        s_d.cnt = s_q.cnt - ONE;
        if (s_q.cnt == ONE) begin
          s_d.st = AMRS_IDLE;
        end
      end
      default: begin
        s_d.st = AMRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: AMRS_IDLE, cs_n: '1, oe_n: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign req_ready = s_q.ready;
  assign read_done = s_q.done;
  assign wait_timeout = s_q.tmo;
  assign read_data = s_q.data;
  assign chip_select_n = s_q.cs_n;
  assign output_enable_n = s_q.oe_n;
  assign write_strobe_n = 1'b1;
  assign bank_address = s_q.ba;
  assign word_address = s_q.addr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_oe_falls_cs: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(output_enable_n) && s_q.ss |-> $fell(&chip_select_n))
    else $error("cs not with oe fall");
  a_oe_rises_cs: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(output_enable_n) && s_q.ss |-> &chip_select_n)
    else $error("cs not with oe rise");
  a_cs_before_oe: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(output_enable_n) && !s_q.ss |-> !$past(&chip_select_n))
    else $error("cs not before oe");
  a_addr_stable_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.st == AMRS_HOLD && $past(s_q.st) == AMRS_HOLD |->
    $stable(word_address) && $stable(bank_address))
    else $error("address moved in hold");
  a_addr_stable_oe: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !output_enable_n |-> $stable(word_address))
    else $error("address moved in strobe");
  a_cs_in_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.st == AMRS_HOLD && !s_q.ss |-> !(&chip_select_n))
    else $error("cs dropped in hold");
  a_strobe_one: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $fell(output_enable_n) && !s_q.ew && read_strobe_cycles == ONE
    |=> output_enable_n)
    else $error("strobe width wrong");
  a_ext_unit: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.st == AMRS_EXTEND && $past(s_q.st) != AMRS_EXTEND
    |-> !output_enable_n [*8])
    else $error("extension too short");
  a_turn_idle: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    s_q.st == AMRS_TURN |-> &chip_select_n && output_enable_n)
    else $error("busy in turnaround");
endmodule // amrs_seq

// ===== amrs_sync.sv
// two flip-flop synchroniser for the wait pin
`timescale 1ns/1ns
module amrs_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // data
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // amrs_sync

// ===== tb_amrs_seq.sv
// self-checking bench for the async read strobe sequencer
`timescale 1ns/1ns
`include "amrs_cfg.svh"
module tb_amrs_seq;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ew = 1'b0;
  logic ss = 1'b0;
  logic req_valid = 1'b0;
  logic [7:0] ta = 8'h00, rs = 8'h01, st = 8'h01, rh = 8'h01, mw = 8'h01;
  logic [7:0] wait_len = 8'h00;
  logic [1:0] bank = 2'h0;
  logic [20:0] addr = 21'h000000;
  logic [3:0] sel = 4'h1;
  logic req_ready, read_done, wait_timeout, wstb_n, wait_in, oe_n, seen, bad;
  logic [15:0] read_data, mem_bus;
  logic [3:0] cs_n;
  logic [1:0] ba_o;
  logic [20:0] wa_o;
  int n_fail = 0, tests_run = 0, cyc = 0, n_set, n_str, n_hld, c;
  // ------------------------------------------------------------
  // design and memory
  // ------------------------------------------------------------
  amrs_seq amrs_seq_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .extended_wait_enable(ew), .select_strobe_mode(ss),
    .turnaround_cycles(ta), .read_setup_cycles(rs), .read_strobe_cycles(st),
    .read_hold_cycles(rh), .max_wait_timeout(mw), .req_valid(req_valid),
    .req_bank(bank), .req_addr(addr), .req_cs_sel(sel),
    .req_ready(req_ready), .read_done(read_done),
    .wait_timeout(wait_timeout), .read_data(read_data),
    .memory_wait_input(wait_in), .memory_data_bus(mem_bus),
    .chip_select_n(cs_n), .output_enable_n(oe_n), .write_strobe_n(wstb_n),
    .bank_address(ba_o), .word_address(wa_o));
  amrs_mem_model amrs_mem_model_i (.ref_clk(ref_clk), .chip_select_n(cs_n),
    .output_enable_n(oe_n), .word_address(wa_o), .memory_wait_input(wait_in),
    .memory_data_bus(mem_bus), .wait_len(wait_len));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // phase monitor, counts whole cycles of setup, strobe and hold while chip select or output enable is active
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
    if (cs_n !== 4'hf || oe_n === 1'b0) begin
      if (oe_n === 1'b0) begin
        n_str++;
        seen = 1'b1;
      end else if (seen) begin
        n_hld++;
      end else begin
        n_set++;
      end
      if (ba_o !== bank || wa_o !== addr) bad = 1'b1;
      if (cs_n !== 4'hf && cs_n !== ~sel) bad = 1'b1;
      if (wstb_n !== 1'b1) bad = 1'b1;
    end
  end
  task automatic chk(input string what, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one read; units of sixteen expected, and the timeout flag
  task automatic rd(input logic [7:0] s, t, h, a, input logic m, e,
    input logic [7:0] mx, wl, input int u, input logic to);
    int total;
    total = s + t + h + 16 * u;
    @(negedge ref_clk);
    rs = s;
    st = t;
    rh = h;
    ta = a;
    ss = m;
    ew = e;
    mw = mx;
    wait_len = wl;
    bank = 2'($urandom);
    addr = 21'($urandom);
    sel = 4'h1 << ($urandom % 4);
    n_set = 0;
    n_str = 0;
    n_hld = 0;
    seen = 1'b0;
    bad = 1'b0;
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    c = 0;
    while (read_done !== 1'b1 && c < 1000) begin
      @(negedge ref_clk);
      c++;
    end
    chk("cycle", total, c);
    chk("setup", m ? 0 : s, n_set);
    chk("strobe", t + 16 * u, n_str);
    chk("hold", m ? 0 : h, n_hld);
    chk("pins", 0, bad);
    chk("data", {16'h0, addr[15:0] ^ 16'ha5c3}, {16'h0, read_data});
    chk("timeout", to, wait_timeout);
    c = 0;
    while (req_ready !== 1'b1 && c < 300) begin
      @(negedge ref_clk);
      c++;
    end
    chk("turn", a + 1, c);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h354e));
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    while (req_ready !== 1'b1) @(negedge ref_clk);
    rd(8'h02, 8'h02, 8'h01, 8'h00, 1'b0, 1'b0, 8'h01, 8'h00, 0, 1'b0);
    rd(8'h01, 8'h01, 8'h01, 8'h03, 1'b1, 1'b0, 8'h01, 8'h00, 0, 1'b0);
    for (int i = 0; i < 12; i++) begin
      rd(8'($urandom_range(1, 4)), 8'($urandom_range(1, 4)),
        8'($urandom_range(1, 4)), 8'($urandom_range(0, 3)),
        1'($urandom), 1'b0, 8'h01, 8'h00, 0, 1'b0);
    end
    // wait pin ignored unless extension is enabled
    rd(8'h02, 8'h06, 8'h02, 8'h01, 1'b0, 1'b0, 8'h04, 8'h0a, 0, 1'b0);
    rd(8'h02, 8'h06, 8'h02, 8'h01, 1'b0, 1'b1, 8'h04, 8'h00, 0, 1'b0);
    rd(8'h02, 8'h06, 8'h02, 8'h01, 1'b0, 1'b1, 8'h04, 8'h0a, 1, 1'b0);
    rd(8'h01, 8'h06, 8'h01, 8'h00, 1'b1, 1'b1, 8'h04, 8'h0a, 1, 1'b0);
    rd(8'h02, 8'h06, 8'h02, 8'h00, 1'b0, 1'b1, 8'h02, 8'hff, 2, 1'b1);
    rd(8'h02, 8'h02, 8'h02, 8'h00, 1'b0, 1'b0, 8'h02, 8'h00, 0, 1'b0);
    finish_test();
  end
endmodule // tb_amrs_seq
